// [core/inset_regs_pkg.sv]
/*
 * Constants of the second-level register bank: first-level gateway
 * addresses, second-level register numbers and field positions.
 * Assumes an 8-bit control bus word and an external serial engine.
 */
package inset_regs_pkg;
    localparam int DW = 8;
    localparam int BANK_DEPTH = 64;
    localparam logic [7:0] RST_VAL = 8'h00;
    // first-level gateway registers
    localparam logic [7:0] FL_SELECT = 8'hD9;
    localparam logic [7:0] FL_READ = 8'hDA;
    localparam logic [7:0] FL_WRITE = 8'hDB;
    // second-level register numbers
    localparam logic [7:0] REG_WR_BYTES = 8'h0A;
    localparam logic [7:0] REG_WR_ROW = 8'h0B;
    localparam logic [7:0] REG_WR_COL = 8'h0C;
    localparam logic [7:0] REG_RD_BYTES = 8'h0D;
    localparam logic [7:0] REG_RD_ROW = 8'h0E;
    localparam logic [7:0] REG_RD_COL = 8'h0F;
    localparam logic [7:0] REG_HOST_ROW = 8'h10;
    localparam logic [7:0] REG_HOST_COL = 8'h11;
    localparam logic [7:0] REG_HOST_WDATA = 8'h12;
    localparam logic [7:0] REG_HOST_RDATA = 8'h13;
    localparam logic [7:0] REG_MODE_THREE = 8'h1E;
    localparam logic [7:0] REG_SHARPEN = 8'h2A;
    localparam logic [7:0] REG_BORDER_LUMA = 8'h2B;
    localparam logic [7:0] REG_MODE_ONE = 8'h2C;
    localparam logic [7:0] REG_BORDER_HSTART = 8'h2D;
    localparam logic [7:0] REG_BORDER_VWIDTH = 8'h2E;
    localparam logic [7:0] REG_FRAME_WIDTH = 8'h2F;
    localparam logic [7:0] REG_LOW_BITS = 8'h31;
    localparam logic [7:0] REG_INSET_HS1 = 8'h32;
    localparam logic [7:0] REG_INSET_HS2 = 8'h33;
    localparam logic [7:0] REG_INSET_WIDTH = 8'h34;
    localparam logic [7:0] REG_BORDER_VSTART = 8'h35;
    localparam logic [7:0] REG_BORDER_HEIGHT = 8'h36;
    localparam logic [7:0] REG_FRAME_HEIGHT = 8'h37;
    localparam logic [7:0] REG_MODE_TWO = 8'h39;
    localparam logic [7:0] REG_LUMINANCE = 8'h3A;
    localparam logic [7:0] REG_BLANKING = 8'h3C;
    // field positions
    localparam int FRAME_LOW_LSB = 2;
    localparam int VWIDTH_LOW_LSB = 4;
    localparam int HSTART_LOW_LSB = 6;
    localparam int SHARPEN_LSB = 6;
    localparam int LUMA_MSB = 4;
    localparam int ANALOG_LSB = 5;
    localparam int LUMINANCE_MSB = 5;
    // bit positions shared by the three mode registers
    localparam int BIT0 = 0;
    localparam int BIT1 = 1;
    localparam int BIT2 = 2;
    localparam int BIT3 = 3;
    localparam int BIT4 = 4;
    localparam int BIT5 = 5;
    localparam int BIT6 = 6;
    localparam int BIT7 = 7;
endpackage

// [core/inset_picture_second_level_regs.sv]
/*
 * Second-level configuration bank of an inset-picture processor,
 * reached through three first-level gateway registers, plus the
 * output-data delay stage that the third mode register controls.
 * Assumes a serial bus engine outside that hands over one whole
 * first-level access per strobe, synchronous to clk_sys.
 */
`timescale 1ns/100ps
module inset_picture_second_level_regs (
    input wire logic clk_sys, // 20 MHz device clock
    input wire logic arst_n, // async reset, active low
    input wire logic fl_we, // completed first-level write
    input wire logic fl_re, // first-level read request
    input wire logic [inset_regs_pkg::DW-1:0] fl_addr, // first-level address
    input wire logic [inset_regs_pkg::DW-1:0] fl_wdata, // first-level write data
    output logic [inset_regs_pkg::DW-1:0] fl_rdata, // read-back data
    output logic fl_rvalid, // read-back valid pulse
    input wire logic [inset_regs_pkg::DW-1:0] host_dram_rdata, // word from DRAM
    output logic host_dram_wr_req, // host DRAM write pulse
    output logic host_dram_rd_req, // host DRAM read pulse
    input wire logic output_data_raw, // undelayed output data
    output logic output_data_signal, // output data, maybe delayed
    output logic inset_enable, // inset picture on
    output logic border_is_digital, // digital border
    output logic magnify_enable, // magnification on
    output logic output_chroma_standard, // output chroma standard
    output logic input_chroma_standard, // input chroma standard
    output logic solo_operation, // stand-alone operation
    output logic progressive_scan_enable, // 2H progressive output
    output logic test_mode, // test mode
    output logic dram_organisation_select, // 64K x 4 DRAMs
    output logic external_colour_enable, // external colour on
    output logic vertical_filter_bypass, // bypass vertical filter
    output logic general_port_output, // general output port
    output logic jitter_free_interlace, // full frame store mode
    output logic reduced_size_enable, // reduced size mode
    output logic external_colour_priority, // external colour wins
    output logic sharpening_bypass, // bypass peaking filter
    output logic alternate_field_enable, // alternate fields
    output logic output_delay_enable, // output data delay on
    output logic [1:0] input_sharpening_select, // peaking filter
    output logic [4:0] border_luma, // digital border luma
    output logic [2:0] analog_border_colour, // one bit per colour
    output logic [9:0] border_horizontal_start, // border h start
    output logic [9:0] vertical_border_width, // vertical border
    output logic [9:0] frame_width_in_border, // frame width
    output logic [7:0] inset_hstart_part_one, // inset h start 1
    output logic [7:0] inset_hstart_part_two, // inset h start 2
    output logic [7:0] inset_width, // inset width
    output logic [7:0] border_vertical_start, // border v start
    output logic [7:0] horizontal_border_height, // border height
    output logic [7:0] frame_height, // frame height
    output logic [5:0] inset_luminance_level, // brightness
    output logic [7:0] output_blanking_width, // output blanking
    output logic [7:0] write_bytes_per_line, // write bytes/line
    output logic [7:0] write_row_start, // write row start
    output logic [7:0] write_column_start, // write column start
    output logic [7:0] read_bytes_per_line, // read bytes/line
    output logic [7:0] read_row_start, // read row start
    output logic [7:0] read_column_start, // read column start
    output logic [7:0] host_row_start, // host row start
    output logic [7:0] host_column_start, // host column start
    output logic [7:0] host_dram_write_data // host write word
);
    import inset_regs_pkg::*;

    typedef logic [BANK_DEPTH-1:0][DW-1:0] bank_t;

    typedef struct packed {
        logic [DW-1:0] sel;
        bank_t bank;
        logic [DW-1:0] rdata;
        logic rvalid;
        logic wr_req;
        logic rd_req;
        logic data_s1;
        logic data_out;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    // registers that exist in the bank; the rest read as zero
    function automatic logic reg_mapped(input logic [DW-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a >= REG_WR_BYTES && a <= REG_HOST_RDATA) begin
            hit = 1'b1;
        end else if (a == REG_MODE_THREE) begin
            hit = 1'b1;
        end else if (a >= REG_SHARPEN && a <= REG_FRAME_WIDTH) begin
            hit = 1'b1;
        end else if (a >= REG_LOW_BITS && a <= REG_FRAME_HEIGHT) begin
            hit = 1'b1;
        end else if (a == REG_MODE_TWO || a == REG_LUMINANCE) begin
            hit = 1'b1;
        end else if (a == REG_BLANKING) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    function automatic logic [DW-1:0] bank_word(input bank_t b,
                                                input logic [DW-1:0] a);
        return b[a[$clog2(BANK_DEPTH)-1:0]];
    endfunction

    logic commit;
    logic select_wr;
    logic read_req;
    assign commit = fl_we && (fl_addr == FL_WRITE);
    assign select_wr = fl_we && (fl_addr == FL_SELECT);
    assign read_req = fl_re && (fl_addr == FL_READ);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = 1'b0;
        nxt_state.wr_req = 1'b0;
        nxt_state.rd_req = 1'b0;
        if (select_wr) begin
            nxt_state.sel = fl_wdata;
            // fetch early so the word is waiting when read back
            nxt_state.rd_req = (fl_wdata == REG_HOST_RDATA);
        end
        // the bank only moves on the strobe that ends a write
        if (commit && reg_mapped(state_ff.sel) &&
                state_ff.sel != REG_HOST_RDATA) begin
            nxt_state.bank[state_ff.sel[$clog2(BANK_DEPTH)-1:0]] = fl_wdata;
            nxt_state.wr_req = (state_ff.sel == REG_HOST_WDATA);
        end
        if (read_req) begin
            nxt_state.rvalid = 1'b1;
            if (state_ff.sel == REG_HOST_RDATA) begin
                nxt_state.rdata = host_dram_rdata;
            end else if (reg_mapped(state_ff.sel)) begin
                nxt_state.rdata = bank_word(state_ff.bank, state_ff.sel);
            end else begin
                nxt_state.rdata = RST_VAL;
            end
        end
        nxt_state.data_s1 = output_data_raw;
        // the delayed path reuses the first stage, so it costs one flop
        if (state_ff.bank[REG_MODE_THREE[5:0]][BIT7]) begin
            nxt_state.data_out = state_ff.data_s1;
        end else begin
            nxt_state.data_out = output_data_raw;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs are straight bit selections of the state_ff flops
    logic [DW-1:0] m1;
    logic [DW-1:0] m2;
    logic [DW-1:0] m3;
    logic [DW-1:0] lowb;
    assign m1 = state_ff.bank[REG_MODE_ONE[5:0]];
    assign m2 = state_ff.bank[REG_MODE_TWO[5:0]];
    assign m3 = state_ff.bank[REG_MODE_THREE[5:0]];
    assign lowb = state_ff.bank[REG_LOW_BITS[5:0]];

    assign fl_rdata = state_ff.rdata;
    assign fl_rvalid = state_ff.rvalid;
    assign host_dram_wr_req = state_ff.wr_req;
    assign host_dram_rd_req = state_ff.rd_req;
    assign output_data_signal = state_ff.data_out;

    assign inset_enable = m1[BIT0];
    assign border_is_digital = m1[BIT1];
    assign magnify_enable = m1[BIT2];
    assign output_chroma_standard = m1[BIT3];
    assign input_chroma_standard = m1[BIT4];
    assign solo_operation = m1[BIT5];
    assign progressive_scan_enable = m1[BIT6];
    assign test_mode = m1[BIT7];

    assign dram_organisation_select = m2[BIT0];
    assign external_colour_enable = m2[BIT1];
    assign vertical_filter_bypass = m2[BIT2];
    assign general_port_output = m2[BIT3];
    assign jitter_free_interlace = m2[BIT4];
    assign reduced_size_enable = m2[BIT5];
    assign external_colour_priority = m2[BIT6];
    assign sharpening_bypass = m2[BIT7];

    assign alternate_field_enable = m3[BIT6];
    assign output_delay_enable = m3[BIT7];

    assign input_sharpening_select =
        state_ff.bank[REG_SHARPEN[5:0]][DW-1:SHARPEN_LSB];
    assign border_luma = state_ff.bank[REG_BORDER_LUMA[5:0]][LUMA_MSB:0];
    assign analog_border_colour =
        state_ff.bank[REG_BORDER_LUMA[5:0]][DW-1:ANALOG_LSB];
    assign border_horizontal_start = {state_ff.bank[REG_BORDER_HSTART[5:0]],
        lowb[HSTART_LOW_LSB+1:HSTART_LOW_LSB]};
    assign vertical_border_width = {state_ff.bank[REG_BORDER_VWIDTH[5:0]],
        lowb[VWIDTH_LOW_LSB+1:VWIDTH_LOW_LSB]};
    assign frame_width_in_border = {state_ff.bank[REG_FRAME_WIDTH[5:0]],
        lowb[FRAME_LOW_LSB+1:FRAME_LOW_LSB]};
    assign inset_hstart_part_one = state_ff.bank[REG_INSET_HS1[5:0]];
    assign inset_hstart_part_two = state_ff.bank[REG_INSET_HS2[5:0]];
    assign inset_width = state_ff.bank[REG_INSET_WIDTH[5:0]];
    assign border_vertical_start = state_ff.bank[REG_BORDER_VSTART[5:0]];
    assign horizontal_border_height = state_ff.bank[REG_BORDER_HEIGHT[5:0]];
    assign frame_height = state_ff.bank[REG_FRAME_HEIGHT[5:0]];
    assign inset_luminance_level =
        state_ff.bank[REG_LUMINANCE[5:0]][LUMINANCE_MSB:0];
    assign output_blanking_width = state_ff.bank[REG_BLANKING[5:0]];
    assign write_bytes_per_line = state_ff.bank[REG_WR_BYTES[5:0]];
    assign write_row_start = state_ff.bank[REG_WR_ROW[5:0]];
    assign write_column_start = state_ff.bank[REG_WR_COL[5:0]];
    assign read_bytes_per_line = state_ff.bank[REG_RD_BYTES[5:0]];
    assign read_row_start = state_ff.bank[REG_RD_ROW[5:0]];
    assign read_column_start = state_ff.bank[REG_RD_COL[5:0]];
    assign host_row_start = state_ff.bank[REG_HOST_ROW[5:0]];
    assign host_column_start = state_ff.bank[REG_HOST_COL[5:0]];
    assign host_dram_write_data = state_ff.bank[REG_HOST_WDATA[5:0]];

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    frame_width_a: assert property (commit && state_ff.sel == REG_FRAME_WIDTH
        |=> frame_width_in_border[9:2] == $past(fl_wdata))
        else $error("frame width upper byte not applied");

    low_bits_a: assert property (commit && state_ff.sel == REG_LOW_BITS
        |=> frame_width_in_border[1:0] == $past(fl_wdata[3:2])
            && vertical_border_width[1:0] == $past(fl_wdata[5:4]))
        else $error("border low bits misplaced");

    hstart_low_a: assert property (commit && state_ff.sel == REG_LOW_BITS
        |=> border_horizontal_start[1:0] == $past(fl_wdata[7:6]))
        else $error("horizontal start low bits misplaced");

    sharpen_sel_a: assert property (commit && state_ff.sel == REG_SHARPEN
        |=> input_sharpening_select == $past(fl_wdata[7:6]))
        else $error("sharpening select wrong");

    border_luma_a: assert property (commit && state_ff.sel == REG_BORDER_LUMA
        |=> border_luma == $past(fl_wdata[4:0])
            && analog_border_colour == $past(fl_wdata[7:5]))
        else $error("border luma or colour wrong");

    brightness_a: assert property (commit && state_ff.sel == REG_LUMINANCE
        |=> inset_luminance_level == $past(fl_wdata[5:0]))
        else $error("brightness field wrong");

    mode_one_a: assert property (commit && state_ff.sel == REG_MODE_ONE
        |=> inset_enable == $past(fl_wdata[0]) && magnify_enable == $past(fl_wdata[2]))
        else $error("mode one bits not applied");

    hold_value_a: assert property (!commit |=> $stable(frame_width_in_border)
        && $stable(inset_enable) && $stable(m2))
        else $error("bank changed without a completed write");

    select_addr_a: assert property (select_wr |=> state_ff.sel == $past(fl_wdata))
        else $error("selection not taken");

    readback_a: assert property (read_req && reg_mapped(state_ff.sel)
        && state_ff.sel != REG_HOST_RDATA
        |=> fl_rvalid && fl_rdata == bank_word(state_ff.bank, $past(state_ff.sel)))
        else $error("read-back word wrong");

    host_write_a: assert property (commit && state_ff.sel == REG_HOST_WDATA
        |=> host_dram_wr_req)
        else $error("host write request missing");

    host_write_only_a: assert property (!(commit && state_ff.sel == REG_HOST_WDATA)
        |=> !host_dram_wr_req)
        else $error("stray host write request");

    host_read_req_a: assert property (select_wr && fl_wdata == REG_HOST_RDATA
        |=> host_dram_rd_req)
        else $error("host read request missing");

    host_read_only_a: assert property (!(select_wr && fl_wdata == REG_HOST_RDATA)
        |=> !host_dram_rd_req)
        else $error("stray host read request");

    host_read_data_a: assert property (read_req && state_ff.sel == REG_HOST_RDATA
        |=> fl_rvalid && fl_rdata == $past(host_dram_rdata))
        else $error("host read data not passed on");

    unmapped_read_a: assert property (read_req && !reg_mapped(state_ff.sel)
        |=> fl_rvalid && fl_rdata == RST_VAL)
        else $error("unmapped register not read as zero");

    read_pulse_a: assert property (!read_req |=> !fl_rvalid)
        else $error("read-back valid without a request");

    inset_hstart_a: assert property (commit && state_ff.sel == REG_INSET_HS1
        |=> inset_hstart_part_one == $past(fl_wdata))
        else $error("inset start part one not applied");

    inset_hstart_two_a: assert property (commit && state_ff.sel == REG_INSET_HS2
        |=> inset_hstart_part_two == $past(fl_wdata))
        else $error("inset start part two not applied");

    write_side_a: assert property (commit && state_ff.sel == REG_WR_BYTES
        |=> write_bytes_per_line == $past(fl_wdata))
        else $error("write-side byte count not applied");

    read_side_a: assert property (commit && state_ff.sel == REG_RD_BYTES
        |=> read_bytes_per_line == $past(fl_wdata))
        else $error("read-side byte count not applied");

    chroma_std_a: assert property (commit && state_ff.sel == REG_MODE_ONE
        |=> output_chroma_standard == $past(fl_wdata[BIT3])
            && input_chroma_standard == $past(fl_wdata[BIT4]))
        else $error("chroma standard bits not applied");

    mode_one_rest_a: assert property (commit && state_ff.sel == REG_MODE_ONE
        |=> border_is_digital == $past(fl_wdata[BIT1])
            && solo_operation == $past(fl_wdata[BIT5])
            && progressive_scan_enable == $past(fl_wdata[BIT6])
            && test_mode == $past(fl_wdata[BIT7]))
        else $error("mode one option bits not applied");

    dram_org_a: assert property (commit && state_ff.sel == REG_MODE_TWO
        |=> dram_organisation_select == $past(fl_wdata[BIT0]))
        else $error("DRAM organisation bit not applied");

    ext_colour_a: assert property (commit && state_ff.sel == REG_MODE_TWO
        |=> external_colour_enable == $past(fl_wdata[BIT1])
            && external_colour_priority == $past(fl_wdata[BIT6]))
        else $error("external colour bits not applied");

    filter_bypass_a: assert property (commit && state_ff.sel == REG_MODE_TWO
        |=> vertical_filter_bypass == $past(fl_wdata[BIT2])
            && sharpening_bypass == $past(fl_wdata[BIT7]))
        else $error("filter bypass bits not applied");

    mode_two_misc_a: assert property (commit && state_ff.sel == REG_MODE_TWO
        |=> general_port_output == $past(fl_wdata[BIT3])
            && jitter_free_interlace == $past(fl_wdata[BIT4])
            && reduced_size_enable == $past(fl_wdata[BIT5]))
        else $error("mode two option bits not applied");

    alt_field_a: assert property (commit && state_ff.sel == REG_MODE_THREE
        |=> alternate_field_enable == $past(fl_wdata[BIT6]))
        else $error("alternate field bit not applied");

    delay_on_a: assert property (output_delay_enable
        |=> output_data_signal == $past(output_data_raw, 2))
        else $error("output data not delayed");

    delay_off_a: assert property (!output_delay_enable
        |=> output_data_signal == $past(output_data_raw))
        else $error("output data delayed when off");

endmodule

// [verif/control_unit_model.sv]
/*
 * Behavioural central control unit: issues whole first-level gateway
 * accesses, one strobe per access, launched on a falling edge.
 * Assumes the bank samples the strobes on the rising clk_sys edge.
 */
`timescale 1ns/100ps
module control_unit_model (
    input wire logic clk_sys, // device clock
    output logic fl_we, // write strobe
    output logic fl_re, // read strobe
    output logic [7:0] fl_addr, // gateway address
    output logic [7:0] fl_wdata // write data
);
    import inset_regs_pkg::*;
    initial begin
        fl_we = 1'b0;
        fl_re = 1'b0;
        fl_addr = 8'h00;
        fl_wdata = 8'h00;
    end
    // entered at a falling edge; the access stands across one rising edge
    task automatic put(input logic we, input logic re, input logic [7:0] a,
                       input logic [7:0] d);
        fl_we = we;
        fl_re = re;
        fl_addr = a;
        fl_wdata = d;
        @(negedge clk_sys);
    endtask
    // released lines carry the inverse, so a stale value never passes for a live one
    task automatic idle(input int gap);
        fl_we = 1'b0;
        fl_re = 1'b0;
        fl_addr = ~fl_addr;
        fl_wdata = ~fl_wdata;
        repeat (gap) @(negedge clk_sys);
    endtask
    task automatic write_reg(input logic [7:0] r, input logic [7:0] v, input int gap);
        put(1'b1, 1'b0, FL_SELECT, r);
        put(1'b1, 1'b0, FL_WRITE, v);
        idle(gap);
    endtask
    task automatic read_reg(input logic [7:0] r, input int gap);
        put(1'b1, 1'b0, FL_SELECT, r);
        put(1'b0, 1'b1, FL_READ, ~fl_wdata);
        idle(gap);
    endtask
endmodule

// [verif/testbench.sv]
/*
 * Self-checking bench for the second-level register bank.
 * Assumes the control unit model drives the gateway and this module
 * plays the DRAM sequencer and the raw output data source.
 */
`timescale 1ns/100ps
module testbench;
    import inset_regs_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n, fl_we, fl_re, fl_rvalid, host_dram_wr_req, host_dram_rd_req;
    logic output_data_raw, output_data_signal, inset_enable, border_is_digital;
    logic magnify_enable, output_chroma_standard, input_chroma_standard, solo_operation;
    logic progressive_scan_enable, test_mode, dram_organisation_select;
    logic external_colour_enable, vertical_filter_bypass, general_port_output;
    logic jitter_free_interlace, reduced_size_enable, external_colour_priority;
    logic sharpening_bypass, alternate_field_enable, output_delay_enable, h1, h2;
    logic [7:0] fl_addr, fl_wdata, fl_rdata, host_dram_rdata, inset_hstart_part_one;
    logic [7:0] inset_hstart_part_two, inset_width, border_vertical_start;
    logic [7:0] horizontal_border_height, frame_height, output_blanking_width;
    logic [7:0] write_bytes_per_line, write_row_start, write_column_start;
    logic [7:0] read_bytes_per_line, read_row_start, read_column_start;
    logic [7:0] host_row_start, host_column_start, host_dram_write_data;
    logic [1:0] input_sharpening_select;
    logic [4:0] border_luma;
    logic [2:0] analog_border_colour;
    logic [9:0] border_horizontal_start, vertical_border_width, frame_width_in_border;
    logic [5:0] inset_luminance_level;
    logic [7:0] vals [64];
    logic [7:0] exp_q [$];
    logic [7:0] regs [26] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
        8'h12, 8'h1E, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h31, 8'h32, 8'h33,
        8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3C};
    int failures = 0;
    int n_compared = 0;
    int n_wr = 0;
    int n_rd = 0;

    control_unit_model ctrl (.clk_sys, .fl_we, .fl_re, .fl_addr, .fl_wdata);

    inset_picture_second_level_regs DUT (.clk_sys, .arst_n, .fl_we, .fl_re, .fl_addr,
        .fl_wdata, .fl_rdata, .fl_rvalid, .host_dram_rdata, .host_dram_wr_req,
        .host_dram_rd_req, .output_data_raw, .output_data_signal, .inset_enable,
        .border_is_digital, .magnify_enable, .output_chroma_standard,
        .input_chroma_standard, .solo_operation, .progressive_scan_enable, .test_mode,
        .dram_organisation_select, .external_colour_enable, .vertical_filter_bypass,
        .general_port_output, .jitter_free_interlace, .reduced_size_enable,
        .external_colour_priority, .sharpening_bypass, .alternate_field_enable,
        .output_delay_enable, .input_sharpening_select, .border_luma,
        .analog_border_colour, .border_horizontal_start, .vertical_border_width,
        .frame_width_in_border, .inset_hstart_part_one, .inset_hstart_part_two,
        .inset_width, .border_vertical_start, .horizontal_border_height, .frame_height,
        .inset_luminance_level, .output_blanking_width, .write_bytes_per_line,
        .write_row_start, .write_column_start, .read_bytes_per_line, .read_row_start,
        .read_column_start, .host_row_start, .host_column_start, .host_dram_write_data);

    always #25 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // unused bits of 0x1E, 0x31 and 0x3A are written as zero, so read-back does not hinge on their storage
    function automatic logic [7:0] used(input logic [7:0] r);
        return (r == 8'h1E) ? 8'hC0 : (r == 8'h31) ? 8'hFC : (r == 8'h3A) ? 8'h3F : 8'hFF;
    endfunction

    task automatic check_fields();
        check(frame_width_in_border, {vals[47], vals[49][3:2]});
        check(vertical_border_width, {vals[46], vals[49][5:4]});
        check(border_horizontal_start, {vals[45], vals[49][7:6]});
        check(input_sharpening_select, vals[42][7:6]);
        check(border_luma, vals[43][4:0]);
        check(analog_border_colour, vals[43][7:5]);
        check(inset_luminance_level, vals[58][5:0]);
        check({inset_hstart_part_one, inset_hstart_part_two}, {vals[50], vals[51]});
        check({write_bytes_per_line, write_row_start, write_column_start},
              {vals[10], vals[11], vals[12]});
        check({read_bytes_per_line, read_row_start, read_column_start},
              {vals[13], vals[14], vals[15]});
        check({host_row_start, host_column_start, host_dram_write_data},
              {vals[16], vals[17], vals[18]});
        check({test_mode, progressive_scan_enable, solo_operation, input_chroma_standard,
               output_chroma_standard, magnify_enable, border_is_digital, inset_enable},
              vals[44]);
        check({sharpening_bypass, external_colour_priority, reduced_size_enable,
               jitter_free_interlace, general_port_output, vertical_filter_bypass,
               external_colour_enable, dram_organisation_select}, vals[57]);
        check({inset_width, border_vertical_start, horizontal_border_height, frame_height},
              {vals[52], vals[53], vals[54], vals[55]});
        check(output_blanking_width, vals[60]);
        check({output_delay_enable, alternate_field_enable}, vals[30][7:6]);
    endtask

    always @(posedge clk_sys) begin
        h2 <= h1;
        h1 <= output_data_raw;
    end

    always @(negedge clk_sys) begin
        output_data_raw <= 1'($urandom);
        if (host_dram_wr_req === 1'b1) n_wr++;
        if (host_dram_rd_req === 1'b1) n_rd++;
        if (fl_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check(fl_rdata, 32'hFFFF_FFFF);
            else check(fl_rdata, exp_q.pop_front());
        end
    end

    initial begin
        arst_n = 1'b0;
        output_data_raw = 1'b0;
        host_dram_rdata = 8'h00;
        void'($urandom(32'h620F));
        foreach (vals[i]) vals[i] = 8'h00;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        check_fields();
        for (int p = 0; p < 2; p++) begin
            foreach (regs[i]) begin
                vals[regs[i]] = (p == 0 ? 8'($urandom) : ~vals[regs[i]]) & used(regs[i]);
                ctrl.write_reg(regs[i], vals[regs[i]], 1 + (i % 3));
                exp_q.push_back(vals[regs[i]]);
                ctrl.read_reg(regs[i], 1);
            end
            check_fields();
        end
        // selection alone, or a read strobe at the data address, must not commit
        ctrl.put(1'b1, 1'b0, FL_SELECT, REG_FRAME_WIDTH);
        ctrl.put(1'b0, 1'b1, FL_WRITE, ~vals[47]);
        ctrl.idle(3);
        check_fields();
        host_dram_rdata = 8'($urandom);
        ctrl.write_reg(REG_HOST_RDATA, ~host_dram_rdata, 1);
        exp_q.push_back(host_dram_rdata);
        ctrl.read_reg(REG_HOST_RDATA, 2);
        ctrl.write_reg(8'h01, 8'hA5, 1);
        exp_q.push_back(8'h00);
        ctrl.read_reg(8'h01, 2);
        check(n_wr, 2);
        check(n_rd, 2);
        for (int e = 0; e < 2; e++) begin
            vals[30] = {e[0], ~e[0], 6'h00};
            ctrl.write_reg(REG_MODE_THREE, vals[30], 4);
            check_fields();
            for (int k = 0; k < 16; k++) begin
                check(output_data_signal, e ? h2 : h1);
                @(negedge clk_sys);
            end
        end
        for (int k = 0; k < 50 && exp_q.size() != 0; k++) @(negedge clk_sys);
        if (exp_q.size() != 0) failures++;
        summarize();
    end
endmodule
